// ---- iscal_map.svh ----
// register indices, reset values, field positions and codes of the input select / calibration block
`ifndef ISCAL_MAP_SVH
`define ISCAL_MAP_SVH

// register indices, byte address is four times the index
`define ISCAL_IDX_PAIR_SEL    6'h06
`define ISCAL_IDX_OFS_LOW     6'h07
`define ISCAL_IDX_OFS_MID     6'h08
`define ISCAL_IDX_OFS_HIGH    6'h09
`define ISCAL_IDX_GAIN_LOW    6'h0a
`define ISCAL_IDX_GAIN_MID    6'h0b
`define ISCAL_IDX_GAIN_HIGH   6'h0c
`define ISCAL_IDX_STATUS      6'h0f

// reset values
`define ISCAL_RST_POS_SEL     4'h0
`define ISCAL_RST_NEG_SEL     4'h1
`define ISCAL_RST_OFS_BYTE    8'h00
`define ISCAL_RST_GAIN_LOW    8'h00
`define ISCAL_RST_GAIN_MID    8'h00
`define ISCAL_RST_GAIN_HIGH   8'h40

// field positions of the pair select register
`define ISCAL_POS_MSB         7
`define ISCAL_POS_LSB         4
`define ISCAL_NEG_MSB         3
`define ISCAL_NEG_LSB         0

// input select codes, shared by both legs
`define ISCAL_SEL_EXT_LAST    4'h9
`define ISCAL_SEL_COMMON      4'ha
`define ISCAL_SEL_TEMP        4'hb
`define ISCAL_SEL_AVDD        4'hc
`define ISCAL_SEL_DVDD        4'hd
`define ISCAL_SEL_TEST        4'he
`define ISCAL_SEL_FLOAT       4'hf

// arithmetic: offset left shift and unity gain exponent (400000h = 2**22)
`define ISCAL_OFS_SHIFT       8
`define ISCAL_GAIN_SHIFT      22
`define ISCAL_PAD_ZERO        8'h00

`endif

// ---- iscal_pkg.sv ----
// types shared by the input select / calibration block
package iscal_pkg;
  typedef logic [3:0]         iscal_sel_t;
  typedef logic signed [31:0] iscal_word_t;
  typedef logic [23:0]        iscal_cal_t;
  typedef logic [7:0]         iscal_byte_t;

  // settings frozen for one conversion
  typedef struct packed {
    iscal_sel_t pos_sel;
    iscal_sel_t neg_sel;
    iscal_cal_t offset;
    iscal_cal_t gain;
  } iscal_cfg_t;
endpackage : iscal_pkg

// ---- iscal_stream_if.sv ----
// valid/ready word stream between the calibration stage and the output buffer
interface iscal_stream_if;
  logic                 valid;
  logic                 ready;
  iscal_pkg::iscal_word_t data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : iscal_stream_if

// ---- iscal_calc.sv ----
// offset subtraction, gain scaling and saturation, one registered stage
`include "iscal_map.svh"
module iscal_calc (
  // clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   reset_n_i,
  // raw sample with its frozen calibration words
  input  wire logic                   in_valid_i,
  output logic                        in_ready_o,
  input  wire iscal_pkg::iscal_word_t in_raw_i,
  input  wire iscal_pkg::iscal_cal_t  in_offset_i,
  input  wire iscal_pkg::iscal_cal_t  in_gain_i,
  // calibrated result
  iscal_stream_if.src                 out
);
  logic signed [32:0] diff;
  logic signed [57:0] prod;
  logic signed [35:0] scaled;
  logic               sat_hi;
  logic               sat_lo;
  iscal_pkg::iscal_word_t result;
  logic               take;
  logic               valid_r;
  iscal_pkg::iscal_word_t data_r;

  // offset word is signed and left aligned to the 32-bit result, subtracted first
  assign diff = $signed({in_raw_i[31], in_raw_i})
              - $signed({in_offset_i[23], in_offset_i, `ISCAL_PAD_ZERO}); // [R7] [R8]
  // gain word over 400000h: multiply, then drop the unity exponent bits
  assign prod   = diff * $signed({1'b0, in_gain_i});                     // [R10] [R11]
  assign scaled = prod[57:`ISCAL_GAIN_SHIFT];                            // [R10]
  // clamp instead of wrap; bits 31 and above must all match the sign
  assign sat_hi = ~scaled[35] & (|scaled[34:31]);                         // [R12]
  assign sat_lo = scaled[35] & ~(&scaled[34:31]);                         // [R12]
  assign result = sat_hi ? 32'sh7fffffff :
                  sat_lo ? 32'sh80000000 : scaled[31:0];                  // [R12]

  // stage empties or drains in the same cycle it refills
  assign take       = in_valid_i & in_ready_o;
  assign in_ready_o = ~valid_r | out.ready;
  assign out.valid  = valid_r;
  assign out.data   = data_r;

  // result register
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      valid_r <= 1'b0;
      data_r  <= '0;
    end else if (in_ready_o) begin
      valid_r <= in_valid_i;
      if (take) begin
        data_r <= result;
      end
    end
  end
endmodule : iscal_calc

// ---- iscal_buf.sv ----
// two-entry output buffer; head entry drives the outputs directly from flops
module iscal_buf (
  // clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   reset_n_i,
  // filling side
  iscal_stream_if.snk                 in,
  // draining side
  output logic                        out_valid_o,
  input  wire logic                   out_ready_i,
  output iscal_pkg::iscal_word_t      out_data_o,
  // fill level
  output logic                        full_o,
  output logic                        empty_o
);
  logic                   head_v_r;
  logic                   tail_v_r;
  iscal_pkg::iscal_word_t head_r;
  iscal_pkg::iscal_word_t tail_r;
  logic                   push;
  logic                   pop;

  // ready is a flop, so a stalled receiver stalls the stage before it
  assign in.ready    = ~tail_v_r;
  assign push        = in.valid & ~tail_v_r;
  assign pop         = head_v_r & out_ready_i;
  assign out_valid_o = head_v_r;
  assign out_data_o  = head_r;
  assign full_o      = tail_v_r;
  assign empty_o     = ~head_v_r;

  // head/tail shift on pop, fill the first free slot on push
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
      head_r   <= '0;
      tail_r   <= '0;
    end else if (pop && tail_v_r) begin
      head_r   <= tail_r;
      tail_v_r <= push;
      if (push) begin
        tail_r <= in.data;
      end
    end else if (pop) begin
      head_v_r <= push;
      if (push) begin
        head_r <= in.data;
      end
    end else if (push && !head_v_r) begin
      head_v_r <= 1'b1;
      head_r   <= in.data;
    end else if (push) begin
      tail_v_r <= 1'b1;
      tail_r   <= in.data;
    end
  end
endmodule : iscal_buf

// ---- iscal_top.sv ----
// input pair select and offset/gain calibration registers with result correction path
//
// Added by the designer: the Wishbone slave port.
`include "iscal_map.svh"

// Summary of operation
// [R1] positive select: inputs 0-9, common, reset 0
// [R2] positive codes b-d pick three internal monitors
// [R3] positive code e test signal, f floats
// [R4] negative select same map, resets to 1
// [R5] negative codes b-e internal negative legs, f floats
// [R6] offset word from three bytes, low first
// [R7] offset signed, left aligned to 32 bits
// [R8] subtract offset before gain correction
// [R9] gain word three bytes, resets to 400000h
// [R10] gain coefficient is word over 400000h
// [R11] multiply corrected result by gain coefficient
// [R12] saturate result at 32-bit limits
// [R13] register writes apply from next conversion
module iscal_top (
  // clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   reset_n_i,
  // classic wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // conversion control
  input  wire logic                   conv_start_i,
  // raw conversion result stream
  input  wire logic                   raw_valid_i,
  output logic                        raw_ready_o,
  input  wire iscal_pkg::iscal_word_t raw_data_i,
  // calibrated result stream
  output logic                        cal_valid_o,
  input  wire logic                   cal_ready_i,
  output iscal_pkg::iscal_word_t      cal_data_o,
  // input routing of the running conversion, index 1 positive, 0 negative
  output iscal_pkg::iscal_sel_t       pos_sel_o,
  output iscal_pkg::iscal_sel_t       neg_sel_o,
  output logic      [1:0]             route_ext_o,
  output logic      [1:0]             route_common_o,
  output logic      [1:0]             route_temp_o,
  output logic      [1:0]             route_avdd_o,
  output logic      [1:0]             route_dvdd_o,
  output logic      [1:0]             route_test_o,
  output logic      [1:0]             route_open_o
);

  // software visible registers
  iscal_pkg::iscal_sel_t  pos_sel_r;
  iscal_pkg::iscal_sel_t  neg_sel_r;
  iscal_pkg::iscal_byte_t ofs_low_r;
  iscal_pkg::iscal_byte_t ofs_mid_r;
  iscal_pkg::iscal_byte_t ofs_high_r;
  iscal_pkg::iscal_byte_t gain_low_r;
  iscal_pkg::iscal_byte_t gain_mid_r;
  iscal_pkg::iscal_byte_t gain_high_r;

  // bus handshake
  logic                   ack_r;
  logic      [31:0]       rdata_r;
  logic                   bus_req;
  logic                   wr_en;
  logic      [5:0]        reg_idx;
  logic                   hit_pair;
  logic                   hit_ofs_low;
  logic                   hit_ofs_mid;
  logic                   hit_ofs_high;
  logic                   hit_gain_low;
  logic                   hit_gain_mid;
  logic                   hit_gain_high;
  logic                   hit_status;
  logic      [7:0]        rd_byte;
  logic      [7:0]        status_byte;

  // assembled words
  iscal_pkg::iscal_cal_t  offset_word;
  iscal_pkg::iscal_cal_t  gain_word;
  iscal_pkg::iscal_cfg_t  shadow_cfg;

  // conversion in flight
  iscal_pkg::iscal_cfg_t  active_r;
  logic                   conv_busy_r;

  // input holding stage
  logic                   in_valid_r;
  logic                   in_valid_nxt;
  iscal_pkg::iscal_word_t in_raw_r;
  iscal_pkg::iscal_cal_t  in_offset_r;
  iscal_pkg::iscal_cal_t  in_gain_r;
  logic                   raw_ready_r;
  logic                   raw_take;
  logic                   calc_ready;
  logic                   calc_take;

  // buffer state
  logic                   buf_full;
  logic                   buf_empty;

  // routing flops, one per leg
  logic      [1:0]        route_ext_r;
  logic      [1:0]        route_common_r;
  logic      [1:0]        route_temp_r;
  logic      [1:0]        route_avdd_r;
  logic      [1:0]        route_dvdd_r;
  logic      [1:0]        route_test_r;
  logic      [1:0]        route_open_r;
  iscal_pkg::iscal_sel_t  leg_code [2];

  // calibration stage to buffer
  iscal_stream_if         cal_stream ();

  // bus decode

  // registers sit one per aligned word; low byte lane carries the data
  assign bus_req       = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_en         = bus_req & wb_we_i & wb_sel_i[0];
  assign reg_idx       = wb_adr_i[7:2];
  assign hit_pair      = (reg_idx == `ISCAL_IDX_PAIR_SEL);
  assign hit_ofs_low   = (reg_idx == `ISCAL_IDX_OFS_LOW);
  assign hit_ofs_mid   = (reg_idx == `ISCAL_IDX_OFS_MID);
  assign hit_ofs_high  = (reg_idx == `ISCAL_IDX_OFS_HIGH);
  assign hit_gain_low  = (reg_idx == `ISCAL_IDX_GAIN_LOW);
  assign hit_gain_mid  = (reg_idx == `ISCAL_IDX_GAIN_MID);
  assign hit_gain_high = (reg_idx == `ISCAL_IDX_GAIN_HIGH);
  assign hit_status    = (reg_idx == `ISCAL_IDX_STATUS);

  // status shows the block's own state, read only
  assign status_byte = {conv_busy_r, in_valid_r, buf_full, buf_empty,
                        active_r.pos_sel};

  // read mux; unmapped indices read zero and still get an ack
  assign rd_byte = hit_pair      ? {pos_sel_r, neg_sel_r} :
                   hit_ofs_low   ? ofs_low_r   :
                   hit_ofs_mid   ? ofs_mid_r   :
                   hit_ofs_high  ? ofs_high_r  :
                   hit_gain_low  ? gain_low_r  :
                   hit_gain_mid  ? gain_mid_r  :
                   hit_gain_high ? gain_high_r :
                   hit_status    ? status_byte : 8'h00;

  // ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= bus_req;
      rdata_r <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // register writes

  // pair select: both legs in one byte
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pos_sel_r <= `ISCAL_RST_POS_SEL;                                 // [R1]
      neg_sel_r <= `ISCAL_RST_NEG_SEL;                                 // [R4]
    end else if (wr_en && hit_pair) begin
      pos_sel_r <= wb_dat_i[`ISCAL_POS_MSB:`ISCAL_POS_LSB];            // [R1]
      neg_sel_r <= wb_dat_i[`ISCAL_NEG_MSB:`ISCAL_NEG_LSB];            // [R4]
    end
  end

  // offset bytes, all zero after reset
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ofs_low_r  <= `ISCAL_RST_OFS_BYTE;                               // [R6]
      ofs_mid_r  <= `ISCAL_RST_OFS_BYTE;
      ofs_high_r <= `ISCAL_RST_OFS_BYTE;
    end else if (wr_en) begin
      if (hit_ofs_low) begin
        ofs_low_r <= wb_dat_i[7:0];
      end
      if (hit_ofs_mid) begin
        ofs_mid_r <= wb_dat_i[7:0];
      end
      if (hit_ofs_high) begin
        ofs_high_r <= wb_dat_i[7:0];
      end
    end
  end

  // gain bytes, unity after reset
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      gain_low_r  <= `ISCAL_RST_GAIN_LOW;                              // [R9]
      gain_mid_r  <= `ISCAL_RST_GAIN_MID;
      gain_high_r <= `ISCAL_RST_GAIN_HIGH;                             // [R9]
    end else if (wr_en) begin
      if (hit_gain_low) begin
        gain_low_r <= wb_dat_i[7:0];
      end
      if (hit_gain_mid) begin
        gain_mid_r <= wb_dat_i[7:0];
      end
      if (hit_gain_high) begin
        gain_high_r <= wb_dat_i[7:0];
      end
    end
  end

  // lowest index holds the least significant byte
  assign offset_word = {ofs_high_r, ofs_mid_r, ofs_low_r};              // [R6]
  assign gain_word   = {gain_high_r, gain_mid_r, gain_low_r};           // [R9]

  assign shadow_cfg.pos_sel = pos_sel_r;
  assign shadow_cfg.neg_sel = neg_sel_r;
  assign shadow_cfg.offset  = offset_word;
  assign shadow_cfg.gain    = gain_word;

  // conversion snapshot

  // settings freeze at the start pulse; a write in the same cycle
  // lands in the shadow copy and waits for the next start
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      active_r.pos_sel <= `ISCAL_RST_POS_SEL;
      active_r.neg_sel <= `ISCAL_RST_NEG_SEL;
      active_r.offset  <= {3{`ISCAL_RST_OFS_BYTE}};
      active_r.gain    <= {`ISCAL_RST_GAIN_HIGH, `ISCAL_RST_GAIN_MID,
                           `ISCAL_RST_GAIN_LOW};
    end else if (conv_start_i) begin
      active_r <= shadow_cfg;                                          // [R13]
    end
  end

  // busy from start until its raw word is taken; a new start wins
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      conv_busy_r <= 1'b0;
    end else if (conv_start_i) begin
      conv_busy_r <= 1'b1;
    end else if (raw_take) begin
      conv_busy_r <= 1'b0;
    end
  end

  // input routing per leg

  assign leg_code[1] = active_r.pos_sel;
  assign leg_code[0] = active_r.neg_sel;

  // both legs share one code map; the leg index picks the source polarity
  for (genvar leg = 0; leg < 2; leg++) begin : g_leg
    always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
        route_ext_r[leg]    <= 1'b1;
        route_common_r[leg] <= 1'b0;
        route_temp_r[leg]   <= 1'b0;
        route_avdd_r[leg]   <= 1'b0;
        route_dvdd_r[leg]   <= 1'b0;
        route_test_r[leg]   <= 1'b0;
        route_open_r[leg]   <= 1'b0;
      end else begin
        route_ext_r[leg]    <= (leg_code[leg] <= `ISCAL_SEL_EXT_LAST);   // [R1] [R4]
        route_common_r[leg] <= (leg_code[leg] == `ISCAL_SEL_COMMON);   // [R1] [R4]
        route_temp_r[leg]   <= (leg_code[leg] == `ISCAL_SEL_TEMP);     // [R2] [R5]
        route_avdd_r[leg]   <= (leg_code[leg] == `ISCAL_SEL_AVDD);     // [R2] [R5]
        route_dvdd_r[leg]   <= (leg_code[leg] == `ISCAL_SEL_DVDD);     // [R2] [R5]
        route_test_r[leg]   <= (leg_code[leg] == `ISCAL_SEL_TEST);     // [R3] [R5]
        route_open_r[leg]   <= (leg_code[leg] == `ISCAL_SEL_FLOAT);    // [R3] [R5]
      end
    end
  end

  // code outputs registered alongside the decoded routes
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pos_sel_o <= `ISCAL_RST_POS_SEL;
      neg_sel_o <= `ISCAL_RST_NEG_SEL;
    end else begin
      pos_sel_o <= active_r.pos_sel;
      neg_sel_o <= active_r.neg_sel;
    end
  end

  assign route_ext_o    = route_ext_r;
  assign route_common_o = route_common_r;
  assign route_temp_o   = route_temp_r;
  assign route_avdd_o   = route_avdd_r;
  assign route_dvdd_o   = route_dvdd_r;
  assign route_test_o   = route_test_r;
  assign route_open_o   = route_open_r;

  // raw input stage

  // ready is registered, so it looks one cycle ahead at the holding slot
  assign raw_take     = raw_valid_i & raw_ready_r;
  assign calc_take    = in_valid_r & calc_ready;
  assign in_valid_nxt = (in_valid_r & ~calc_take) | raw_take;

  // each raw word carries the calibration of the conversion it belongs to
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      in_valid_r  <= 1'b0;
      raw_ready_r <= 1'b0;
      in_raw_r    <= '0;
      in_offset_r <= '0;
      in_gain_r   <= '0;
    end else begin
      in_valid_r  <= in_valid_nxt;
      raw_ready_r <= ~in_valid_nxt;
      if (raw_take) begin
        in_raw_r    <= raw_data_i;
        in_offset_r <= active_r.offset;                                // [R13]
        in_gain_r   <= active_r.gain;                                  // [R13]
      end
    end
  end

  assign raw_ready_o = raw_ready_r;

  // correction and buffering

  // offset, gain and clamp in one registered stage
  iscal_calc u_calc (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (in_valid_r),
    .in_ready_o  (calc_ready),
    .in_raw_i    (in_raw_r),
    .in_offset_i (in_offset_r),
    .in_gain_i   (in_gain_r),
    .out         (cal_stream.src)
  );

  // two entries so a stalled receiver loses no word
  iscal_buf u_buf (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .in          (cal_stream.snk),
    .out_valid_o (cal_valid_o),
    .out_ready_i (cal_ready_i),
    .out_data_o  (cal_data_o),
    .full_o      (buf_full),
    .empty_o     (buf_empty)
  );

endmodule : iscal_top

// ---- iscal_top_monitor.sv ----
// port checker for the input select and calibration block, with its bind
module iscal_mon (
  // clock and reset
  input wire logic                   clock_i,
  input wire logic                   reset_n_i,
  // bus
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  // conversion and result
  input wire logic                   conv_start_i,
  input wire logic                   cal_valid_o,
  input wire logic                   cal_ready_i,
  input wire iscal_pkg::iscal_word_t cal_data_o,
  // routing
  input wire iscal_pkg::iscal_sel_t  pos_sel_o,
  input wire iscal_pkg::iscal_sel_t  neg_sel_o,
  input wire logic [1:0]             route_ext_o,
  input wire logic [1:0]             route_common_o,
  input wire logic [1:0]             route_temp_o,
  input wire logic [1:0]             route_avdd_o,
  input wire logic [1:0]             route_dvdd_o,
  input wire logic [1:0]             route_test_o,
  input wire logic [1:0]             route_open_o
);
  // one clock domain, reset silences every check
  default clocking mon_cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  // bus answer is exactly one cycle after the take
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");

  // routing must follow the frozen codes on each leg
  pos_ext_a: assert property (route_ext_o[1] == (pos_sel_o <= 4'h9))
    else $error("positive external route wrong");
  pos_mon_a: assert property (route_avdd_o[1] == (pos_sel_o == 4'hc))
    else $error("positive monitor route wrong");
  pos_tst_a: assert property (route_test_o[1] == (pos_sel_o == 4'he))
    else $error("positive test route wrong");
  neg_low_a: assert property (route_common_o[0] == (neg_sel_o == 4'ha))
    else $error("negative common route wrong");
  neg_high_a: assert property (route_open_o[0] == (neg_sel_o == 4'hf))
    else $error("negative open route wrong");
  // settings only move two edges after a start
  sel_late_a: assert property ($changed({pos_sel_o, neg_sel_o}) && $past(reset_n_i) |->
    $past(conv_start_i, 2)) else $error("select moved without start");
  // a stalled result must stand
  cal_hold_a: assert property (cal_valid_o && !cal_ready_i |=> cal_valid_o && $stable(cal_data_o))
    else $error("stalled result changed");

  cover property (wb_ack_o && wb_cyc_i);
  cover property (cal_valid_o && !cal_ready_i);
  cover property (route_open_o[1] && route_temp_o[0] == 1'b0);
endmodule : iscal_mon

bind iscal_top iscal_mon u_mon (
  .clock_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .conv_start_i,
  .cal_valid_o, .cal_ready_i, .cal_data_o, .pos_sel_o, .neg_sel_o, .route_ext_o,
  .route_common_o, .route_temp_o, .route_avdd_o, .route_dvdd_o, .route_test_o, .route_open_o
);

// ---- tb.sv ----
// self-checking bench for the input select and calibration block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // design ports
  logic                   clock_i = 1'b0;
  logic                   reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]             wb_adr_i;
  logic [3:0]             wb_sel_i;
  logic [31:0]            wb_dat_i, wb_dat_o;
  logic                   conv_start_i, raw_valid_i, raw_ready_o, cal_valid_o, cal_ready_i;
  iscal_pkg::iscal_word_t raw_data_i, cal_data_o;
  iscal_pkg::iscal_sel_t  pos_sel_o, neg_sel_o;
  logic [1:0]             route_ext_o, route_common_o, route_temp_o, route_avdd_o;
  logic [1:0]             route_dvdd_o, route_test_o, route_open_o;
  // bench state
  int                     err_total, tests_run;
  logic [23:0]            ofs_m, gain_m;
  logic [31:0]            rd;
  logic [31:0]            exp_q[$];
  wire logic [13:0]       route_all = {route_ext_o, route_common_o, route_temp_o,
                                       route_avdd_o, route_dvdd_o, route_test_o, route_open_o};

  iscal_top dut (.clock_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .conv_start_i, .raw_valid_i, .raw_ready_o, .raw_data_i,
    .cal_valid_o, .cal_ready_i, .cal_data_o, .pos_sel_o, .neg_sel_o, .route_ext_o,
    .route_common_o, .route_temp_o, .route_avdd_o, .route_dvdd_o, .route_test_o, .route_open_o);

  // 20 MHz clock
  always #25 clock_i = ~clock_i;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task test_done;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // one classic bus cycle, waits for ack
  task bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, 1'b1, we, a, 24'h0, d};
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : bus

  // expected routing, bit pairs ordered ext down to open
  function automatic logic [13:0] rexp(input logic [3:0] p, input logic [3:0] n);
    logic [6:0] ph, nh;
    logic [13:0] e;
    ph = 7'h40 >> (p <= 4'h9 ? 4'h0 : p - 4'h9);
    nh = 7'h40 >> (n <= 4'h9 ? 4'h0 : n - 4'h9);
    for (int k = 0; k < 7; k++) e[2*k +: 2] = {ph[k], nh[k]};
    return e;
  endfunction : rexp

  // reference correction; longint keeps the full product
  function automatic logic [31:0] model(input logic [31:0] raw);
    longint p;
    p = longint'($signed(raw)) - (longint'($signed(ofs_m)) <<< 8);
    p = (p * longint'(gain_m)) >>> 22;
    if (p > 64'sh7fffffff) return 32'h7fffffff;
    if (p < -64'sh80000000) return 32'h80000000;
    return p[31:0];
  endfunction : model

  task setcal(input logic [23:0] o, input logic [23:0] g);
    ofs_m = o;
    gain_m = g;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h1c + 8'(4 * i), o[8*i +: 8]);
      bus(1'b1, 8'h28 + 8'(4 * i), g[8*i +: 8]);
    end
  endtask : setcal

  task start;
    @(posedge clock_i);
    conv_start_i <= 1'b1;
    @(posedge clock_i);
    conv_start_i <= 1'b0;
  endtask : start

  // start, optionally rewrite offset mid-conversion, then offer the raw word
  task send(input logic [31:0] raw, input logic late);
    start();
    exp_q.push_back(model(raw));
    if (late) begin
      bus(1'b1, 8'h24, 8'h55);
      ofs_m[23:16] = 8'h55;
    end
    {raw_valid_i, raw_data_i} <= {1'b1, raw};
    do @(posedge clock_i); while (raw_ready_o !== 1'b1);
    raw_valid_i <= 1'b0;
  endtask : send

  task drain(input int cnt);
    cal_ready_i <= 1'b1;
    repeat (cnt) begin
      do @(posedge clock_i); while (cal_valid_o !== 1'b1);
      chk(cal_data_o, exp_q.pop_front());
    end
    cal_ready_i <= 1'b0;
  endtask : drain

  // reset values and idle status, then an unmapped place
  task chk_reset;
    logic [7:0] adr [9] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h04, 8'h3c};
    logic [7:0] val [9] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h10};
    chk(route_all, rexp(4'h0, 4'h1));
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, adr[i], 8'h00);
      chk(rd, val[i]);
    end
    bus(1'b1, 8'h04, 8'hff);
    bus(1'b0, 8'h04, 8'h00);
    chk(rd, 32'h0);
  endtask : chk_reset

  // all sixteen codes on both legs
  task chk_mux;
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      bus(1'b1, 8'h18, {c, ~c});
      bus(1'b0, 8'h18, 8'h00);
      chk(rd, {24'h0, c, ~c});
      start();
      repeat (3) @(posedge clock_i);
      chk({pos_sel_o, neg_sel_o}, {c, ~c});
      chk(route_all, rexp(c, ~c));
    end
  endtask : chk_mux

  // offset sign, alignment, order, gain and both saturation limits
  task chk_cal;
    logic [79:0] cv [7] = '{{24'h000000, 24'h400000, 32'h12345678},
      {24'h000100, 24'h400000, 32'h00010000}, {24'hffffff, 24'h400000, 32'h00000000},
      {24'h001000, 24'h600000, 32'h01000000}, {24'h000000, 24'h800000, 32'h40000000},
      {24'h000000, 24'h800000, 32'hb0000000}, {24'h000000, 24'h200000, 32'hffffffff}};
    for (int i = 0; i < 7; i++) begin
      setcal(cv[i][79:56], cv[i][55:32]);
      send(cv[i][31:0], 1'b0);
      drain(1);
    end
  endtask : chk_cal

  // a write during a conversion waits for the next start
  task chk_late;
    setcal(24'h0, 24'h400000);
    send(32'h00100000, 1'b1);
    send(32'h00100000, 1'b0);
    drain(2);
  endtask : chk_late

  // four words fill the path, then the source is held off
  task chk_fill;
    for (int i = 1; i < 5; i++) send(32'(i), 1'b0);
    repeat (10) @(posedge clock_i);
    chk(raw_ready_o, 1'b0);
    drain(4);
  endtask : chk_fill

  // bench main sequence
  initial begin
    {reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {conv_start_i, raw_valid_i, raw_data_i, cal_ready_i} = '0;
    wb_sel_i = 4'hf;
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    chk_reset();
    chk_mux();
    chk_cal();
    chk_late();
    chk_fill();
    test_done();
  end

  // watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    test_done();
  end
endmodule : tb
